/* File: rtl/frc_consts.svh */
// Constants of the fault reaction controller: offsets, fields, resets, times.
// Included by the package user; definitions only.
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH
`define FRC_CLK_MHZ 100
`define FRC_BLANK_NS 250
`define FRC_QUAL_NS 500
`define FRC_TICK_MS 100
`define FRC_OFF_CTRL 8'h00
`define FRC_OFF_RESTART 8'h04
`define FRC_OFF_SSTEP 8'h08
`define FRC_OFF_START 8'h0c
`define FRC_OFF_OUTLVL 8'h10
`define FRC_OFF_INLVL 8'h14
`define FRC_OFF_INSTART 8'h18
`define FRC_OFF_DRIVE 8'h1c
`define FRC_OFF_STATUS 8'h20
`define FRC_OFF_FAULT 8'h24
`define FRC_B_VCCOV_AUTO 0
`define FRC_B_OUTOV_LATCH 1
`define FRC_B_OUTUV_EN 2
`define FRC_B_INOV_EN 3
`define FRC_B_INUV_EN 4
`define FRC_B_OUTCUR_EN 5
`define FRC_B_OUTOV_FAST 6
`define FRC_B_OUTCUR_FAST 7
`define FRC_F_VCCOV 0
`define FRC_F_OUTOV 1
`define FRC_F_OUTUV 2
`define FRC_F_STARTUV 3
`define FRC_F_INOV 4
`define FRC_F_INUV 5
`define FRC_F_HARDOC 6
`define FRC_F_CURAVG 7
`define FRC_F_CURPK 8
`define FRC_F_EXTL 9
`define FRC_F_EXTA 10
`define FRC_RST_CTRL 32'h0000_0000
`define FRC_RST_RESTART 32'h0000_040a
`define FRC_RST_SSTEP 32'h0001_86a0
`define FRC_RST_START 32'h0005_0000
`define FRC_RST_DRIVE 32'h0000_001e
`define FRC_DRV_MIN 7'h1e
`define FRC_DRV_MAX 7'h76
`define FRC_SS_STEPS 2'h3
`endif

/* File: rtl/frc_pkg.sv */
// Types of the fault reaction controller.
// Constants live in frc_consts.svh.
package frc_pkg;
  typedef enum logic [2:0] {
    FRC_OFF = 3'b000,
    FRC_SOFT = 3'b001,
    FRC_CHARGE = 3'b010,
    FRC_RUN = 3'b011,
    FRC_WAIT = 3'b100,
    FRC_LATCH = 3'b101
  } frc_state_e;
  typedef logic [10:0] frc_fault_t;
endpackage

/* File: rtl/frc_top.sv */
// Fault reaction controller of a flyback converter, AXI4-Lite registers.
// Assumes aresetn comes from supply undervoltage lockout.
//
// Notes on behaviour
// - Auto-restart stops gate switching and enters minimum consumption.
// - Auto-restart waits the restart delay then starts up again.
// - During the wait the start-up cell keeps supply between hold levels.
// - Restart charges supply to turn-on level, then normal start with soft start.
// - Latch stops switching at once and keeps supply with the start-up cell.
// - Latch persists until undervoltage lockout; only power-up restarts.
// - Run at turn-on level with no fault; stop below turn-off level.
// - Supply overvoltage always watched; latch by default, auto-restart optional.
// - Output over-voltage picks auto-restart or latch from a setting.
// - Output over level configurable; under level is half the dimmed minimum.
// - Output undervoltage armed after start-up when enabled; auto-restarts.
// - Output below start level at start-up timeout flags a fault, auto-restart.
// - Output over-voltage and over-current pick slow or fast restart delay.
// - Input peak over level latches, under level auto-restarts, each enabled.
// - Start after input fault needs peak inside the start window.
// - Cycle limit ends the gate pulse; comparator blanked after turn-on.
// - Hard limit latches only when held longer than the qualify time.
// - Output current checks armed after start-up, auto-restart.
// - Drive source current setting held between 30 mA and 118 mA.
// - Soft start raises the limit in three timed steps before regulation.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "frc_consts.svh"
module frc_top #(
  parameter int unsigned TICK_CYCLES = `FRC_TICK_MS * 1000 * `FRC_CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Comparator pins, asynchronous
  input wire logic supply_turn_on_level,
  input wire logic supply_turn_off_level,
  input wire logic supply_hold_low_level,
  input wire logic supply_hold_high_level,
  input wire logic supply_max_level,
  input wire logic cycle_current_limit,
  input wire logic hard_current_limit,
  // Measurement logic, same clock
  input wire logic pwm_req,
  input wire logic [11:0] vout_meas,
  input wire logic [11:0] vin_peak,
  input wire logic iout_avg_over,
  input wire logic iout_peak_over,
  input wire logic ext_latch_fault,
  input wire logic ext_auto_fault,
  // Power stage
  output logic switch_drive_out,
  output logic startup_cell_input,
  output logic [1:0] current_limit_step,
  output logic [6:0] drive_peak_source_current,
  output logic converter_running
);
  import frc_pkg::*;

  localparam int BLANK_CYC = (`FRC_BLANK_NS * `FRC_CLK_MHZ + 999) / 1000;
  localparam int QUAL_CYC = (`FRC_QUAL_NS * `FRC_CLK_MHZ + 999) / 1000;

  // Tick counter is 24 bits wide
  if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00ff_ffff)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // Pin synchronisers: change taken once stages two and three agree
  logic [6:0] pin_raw;
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] s3_q;
  logic [6:0] pin_q;
  assign pin_raw = {hard_current_limit, cycle_current_limit, supply_max_level,
                    supply_hold_high_level, supply_hold_low_level,
                    supply_turn_off_level, supply_turn_on_level};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end
        else if (ce)
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            pin_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate
  logic vcc_on, vcc_off, vcc_low, vcc_high, vcc_max, cs1, cs2;
  assign {cs2, cs1, vcc_max, vcc_high, vcc_low, vcc_off, vcc_on} = pin_q;

  // Registers
  logic [31:0] ctrl_q, restart_q, sstep_q, start_q, outlvl_q;
  logic [31:0] inlvl_q, instart_q, drive_q;
  frc_fault_t fault_q;
  frc_fault_t fault_set;
  frc_fault_t fault_clr;
  frc_state_e state_q;
  frc_state_e state_d;

  // AXI write and read channels
  logic aw_held, w_held, wr_go, wr_ok, rd_ok;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [31:0] rd_val;
  assign aw_held = !awready;
  assign w_held = !wready;
  assign wr_go = aw_held && w_held && !bvalid;
  always_comb
  begin
    wr_ok = 1'b1;
    case (awaddr_q)
      `FRC_OFF_CTRL, `FRC_OFF_RESTART, `FRC_OFF_SSTEP, `FRC_OFF_START,
      `FRC_OFF_OUTLVL, `FRC_OFF_INLVL, `FRC_OFF_INSTART, `FRC_OFF_DRIVE,
      `FRC_OFF_STATUS, `FRC_OFF_FAULT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        wdata_q <= wdata;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Byte enables merged into the addressed word
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction
  logic [3:0] wstrb_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wstrb_q <= 4'h0;
    else if (ce && wvalid && wready)
      wstrb_q <= wstrb;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `FRC_RST_CTRL;
      restart_q <= `FRC_RST_RESTART;
      sstep_q <= `FRC_RST_SSTEP;
      start_q <= `FRC_RST_START;
      outlvl_q <= 32'h0;
      inlvl_q <= 32'h0;
      instart_q <= 32'h0;
      drive_q <= `FRC_RST_DRIVE;
    end
    else if (ce && wr_go)
    begin
      case (awaddr_q)
        `FRC_OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        `FRC_OFF_RESTART: restart_q <= merge(restart_q, wdata_q, wstrb_q);
        `FRC_OFF_SSTEP: sstep_q <= merge(sstep_q, wdata_q, wstrb_q);
        `FRC_OFF_START: start_q <= merge(start_q, wdata_q, wstrb_q);
        `FRC_OFF_OUTLVL: outlvl_q <= merge(outlvl_q, wdata_q, wstrb_q);
        `FRC_OFF_INLVL: inlvl_q <= merge(inlvl_q, wdata_q, wstrb_q);
        `FRC_OFF_INSTART: instart_q <= merge(instart_q, wdata_q, wstrb_q);
        `FRC_OFF_DRIVE: drive_q <= merge(drive_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end
  assign fault_clr = (wr_go && awaddr_q == `FRC_OFF_FAULT && wstrb_q[0] && wstrb_q[1])
                     ? wdata_q[10:0] : 11'h000;

  always_comb
  begin
    rd_ok = 1'b1;
    case (araddr)
      `FRC_OFF_CTRL: rd_val = ctrl_q;
      `FRC_OFF_RESTART: rd_val = restart_q;
      `FRC_OFF_SSTEP: rd_val = sstep_q;
      `FRC_OFF_START: rd_val = start_q;
      `FRC_OFF_OUTLVL: rd_val = outlvl_q;
      `FRC_OFF_INLVL: rd_val = inlvl_q;
      `FRC_OFF_INSTART: rd_val = instart_q;
      `FRC_OFF_DRIVE: rd_val = drive_q;
      `FRC_OFF_STATUS: rd_val = {24'h0, current_limit_step, startup_cell_input,
                                 switch_drive_out, 1'b0, state_q};
      `FRC_OFF_FAULT: rd_val = {21'h0, fault_q};
      default:
      begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Fault detection
  logic armed, starting, hard_trip;
  logic [11:0] uv_level;
  logic [15:0] qual_q;
  assign armed = (state_q == FRC_RUN);
  assign starting = (state_q == FRC_SOFT) || (state_q == FRC_CHARGE);
  assign uv_level = {1'b0, outlvl_q[27:17]};
  assign hard_trip = (qual_q >= 16'(QUAL_CYC));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      qual_q <= 16'h0;
    else if (ce)
      qual_q <= !cs2 ? 16'h0 : (hard_trip ? qual_q : qual_q + 16'h1);
  end
  logic start_to;
  always_comb
  begin
    fault_set = '0;
    fault_set[`FRC_F_VCCOV] = vcc_max;
    fault_set[`FRC_F_OUTOV] = vout_meas > outlvl_q[11:0];
    fault_set[`FRC_F_OUTUV] = armed && ctrl_q[`FRC_B_OUTUV_EN] && vout_meas < uv_level;
    fault_set[`FRC_F_STARTUV] = start_to;
    fault_set[`FRC_F_INOV] = ctrl_q[`FRC_B_INOV_EN] && vin_peak > inlvl_q[11:0];
    fault_set[`FRC_F_INUV] = ctrl_q[`FRC_B_INUV_EN] && vin_peak < inlvl_q[27:16];
    fault_set[`FRC_F_HARDOC] = hard_trip;
    fault_set[`FRC_F_CURAVG] = armed && ctrl_q[`FRC_B_OUTCUR_EN] && iout_avg_over;
    fault_set[`FRC_F_CURPK] = armed && ctrl_q[`FRC_B_OUTCUR_EN] && iout_peak_over;
    fault_set[`FRC_F_EXTL] = ext_latch_fault;
    fault_set[`FRC_F_EXTA] = ext_auto_fault;
  end
  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_q <= '0;
    else if (ce)
      fault_q <= (fault_q & ~fault_clr) | fault_set;
  end

  // Reaction selection
  logic latch_ev, auto_ev, fast_ev, vcc_latch, outov_latch;
  assign vcc_latch = !ctrl_q[`FRC_B_VCCOV_AUTO];
  assign outov_latch = ctrl_q[`FRC_B_OUTOV_LATCH];
  assign latch_ev = (fault_set[`FRC_F_VCCOV] && vcc_latch) || (fault_set[`FRC_F_OUTOV] && outov_latch)
                    || fault_set[`FRC_F_INOV] || fault_set[`FRC_F_HARDOC] || fault_set[`FRC_F_EXTL];
  assign auto_ev = (fault_set[`FRC_F_VCCOV] && !vcc_latch) || (fault_set[`FRC_F_OUTOV] && !outov_latch)
                   || |{fault_set[`FRC_F_OUTUV], fault_set[`FRC_F_STARTUV], fault_set[`FRC_F_INUV],
                        fault_set[`FRC_F_CURAVG], fault_set[`FRC_F_CURPK], fault_set[`FRC_F_EXTA]};
  assign fast_ev = (fault_set[`FRC_F_OUTOV] && ctrl_q[`FRC_B_OUTOV_FAST])
                   || ((fault_set[`FRC_F_CURAVG] || fault_set[`FRC_F_CURPK]) && ctrl_q[`FRC_B_OUTCUR_FAST]);

  // Time base in 100 ms ticks
  logic [23:0] tick_q;
  logic tick;
  logic [7:0] delay_q;
  logic [7:0] tmo_q;
  logic [31:0] step_q;
  logic [1:0] level_q;
  assign tick = (tick_q == 24'(TICK_CYCLES - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_q <= 24'h0;
    else if (ce)
      tick_q <= tick ? 24'h0 : tick_q + 24'h1;
  end
  assign start_to = (state_q == FRC_CHARGE) && tick && tmo_q >= start_q[23:16]
                    && vout_meas < start_q[11:0];
  logic in_window;
  assign in_window = !(ctrl_q[`FRC_B_INOV_EN] || ctrl_q[`FRC_B_INUV_EN])
                     || (vin_peak >= instart_q[11:0] && vin_peak <= instart_q[27:16]);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FRC_OFF:
        if (vcc_on && in_window && !latch_ev && !auto_ev)
          state_d = FRC_SOFT;
      FRC_SOFT:
        if (level_q == `FRC_SS_STEPS)
          state_d = FRC_CHARGE;
      FRC_CHARGE:
        if (vout_meas >= start_q[11:0])
          state_d = FRC_RUN;
      FRC_RUN: ;
      FRC_WAIT:
        if (tick && delay_q == 8'h0)
          state_d = FRC_OFF;
      FRC_LATCH: ;
      default: state_d = FRC_OFF;
    endcase
    if (state_q != FRC_LATCH)
    begin
      if (latch_ev)
        state_d = FRC_LATCH;
      else if (auto_ev && state_q != FRC_WAIT && state_q != FRC_OFF)
        state_d = FRC_WAIT;
      else if (vcc_off && state_q != FRC_WAIT)
        state_d = FRC_OFF;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= FRC_OFF;
    else if (ce)
      state_q <= state_d;
  end

  // Restart delay, start-up timeout, soft start steps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      delay_q <= 8'h0;
      tmo_q <= 8'h0;
      step_q <= 32'h0;
      level_q <= 2'h0;
    end
    else if (ce)
    begin
      if (state_d == FRC_WAIT && state_q != FRC_WAIT)
        delay_q <= fast_ev ? restart_q[15:8] : restart_q[7:0];
      else if (tick && delay_q != 8'h0)
        delay_q <= delay_q - 8'h1;
      if (!starting)
        tmo_q <= 8'h0;
      else if (tick && tmo_q != 8'hff)
        tmo_q <= tmo_q + 8'h1;
      if (state_q != FRC_SOFT)
      begin
        step_q <= 32'h0;
        level_q <= (state_q == FRC_OFF) ? 2'h0 : level_q;
      end
      // Top level reached: hold it, a short step must not wrap it
      else if (level_q == `FRC_SS_STEPS)
        step_q <= 32'h0;
      else if (step_q + 32'h1 >= sstep_q)
      begin
        step_q <= 32'h0;
        level_q <= level_q + 2'h1;
      end
      else
        step_q <= step_q + 32'h1;
    end
  end

  // Gate drive with blanking and cycle termination
  logic pwm_d1_q, cut_q, gate_ok;
  logic [7:0] blank_q;
  assign gate_ok = starting || armed;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_d1_q <= 1'b0;
      cut_q <= 1'b0;
      blank_q <= 8'h0;
      switch_drive_out <= 1'b0;
    end
    else if (ce)
    begin
      pwm_d1_q <= pwm_req;
      if (pwm_req && !pwm_d1_q)
      begin
        blank_q <= 8'(BLANK_CYC);
        cut_q <= 1'b0;
      end
      else if (blank_q != 8'h0)
        blank_q <= blank_q - 8'h1;
      else if (cs1 && pwm_req)
        cut_q <= 1'b1;
      switch_drive_out <= pwm_req && gate_ok && state_d == state_q
                          && !(cut_q || (blank_q == 8'h0 && cs1 && !(pwm_req && !pwm_d1_q)));
    end
  end

  // Start-up cell hysteresis, other outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      startup_cell_input <= 1'b1;
      current_limit_step <= 2'h0;
      drive_peak_source_current <= `FRC_DRV_MIN;
      converter_running <= 1'b0;
    end
    else if (ce)
    begin
      if (state_q == FRC_OFF)
        startup_cell_input <= !vcc_on;
      else if (state_q == FRC_WAIT || state_q == FRC_LATCH)
      begin
        if (vcc_low)
          startup_cell_input <= 1'b1;
        else if (vcc_high)
          startup_cell_input <= 1'b0;
      end
      else
        startup_cell_input <= 1'b0;
      current_limit_step <= level_q;
      if (drive_q[6:0] < `FRC_DRV_MIN)
        drive_peak_source_current <= `FRC_DRV_MIN;
      else if (drive_q[6:0] > `FRC_DRV_MAX)
        drive_peak_source_current <= `FRC_DRV_MAX;
      else
        drive_peak_source_current <= drive_q[6:0];
      converter_running <= armed;
    end
  end

  // Checks
  sequence s_latch;
    ce && latch_ev && state_q != FRC_LATCH;
  endsequence
  property p_latch_sw;
    @(posedge aclk) disable iff (!aresetn) s_latch |=> ##1 !switch_drive_out;
  endproperty
  a_latch_sw: assert property (p_latch_sw) else $error("drive after latch");
  property p_latch_stay;
    @(posedge aclk) disable iff (!aresetn) state_q == FRC_LATCH |=> state_q == FRC_LATCH;
  endproperty
  a_latch_stay: assert property (p_latch_stay) else $error("latch left");
  property p_wait_sw;
    @(posedge aclk) disable iff (!aresetn) state_q == FRC_WAIT && $past(state_q) == FRC_WAIT |-> !switch_drive_out;
  endproperty
  a_wait_sw: assert property (p_wait_sw) else $error("drive in wait");
  property p_wait_exit;
    @(posedge aclk) disable iff (!aresetn) $past(state_q) == FRC_WAIT && state_q == FRC_OFF |-> $past(tick);
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("early restart");
  property p_cell;
    @(posedge aclk) disable iff (!aresetn) ce && state_q == FRC_LATCH && vcc_low |=> startup_cell_input;
  endproperty
  a_cell: assert property (p_cell) else $error("cell off below low");
  property p_prio;
    @(posedge aclk) disable iff (!aresetn) ce && latch_ev && auto_ev |=> state_q == FRC_LATCH;
  endproperty
  a_prio: assert property (p_prio) else $error("latch lost priority");
  property p_hard;
    @(posedge aclk) disable iff (!aresetn) fault_q[`FRC_F_HARDOC] && !$past(fault_q[`FRC_F_HARDOC]) |-> $past(cs2, 2);
  endproperty
  a_hard: assert property (p_hard) else $error("hard trip unqualified");
  property p_drv;
    @(posedge aclk) disable iff (!aresetn)
      drive_peak_source_current >= `FRC_DRV_MIN && drive_peak_source_current <= `FRC_DRV_MAX;
  endproperty
  a_drv: assert property (p_drv) else $error("drive current out of range");
  property p_run;
    @(posedge aclk) disable iff (!aresetn) $rose(state_q == FRC_CHARGE) |-> $past(level_q) == `FRC_SS_STEPS;
  endproperty
  a_run: assert property (p_run) else $error("soft start short");
endmodule

/* File: tb/frc_top_bench.sv */
// Self-checking bench of the fault reaction controller.
// Drives every port itself; registers reached by AXI4-Lite master tasks.
`timescale 1ns/100ps
`include "frc_consts.svh"
module frc_top_bench;
  import frc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, switch_drive_out, startup_cell_input, converter_running;
  logic [1:0] bresp, rresp, current_limit_step;
  logic [6:0] drive_peak_source_current;
  logic supply_turn_on_level = 1'b0, supply_turn_off_level = 1'b0, supply_hold_low_level = 1'b0;
  logic supply_hold_high_level = 1'b0, supply_max_level = 1'b0, cycle_current_limit = 1'b0;
  logic hard_current_limit = 1'b0, pwm_req = 1'b0, iout_avg_over = 1'b0, iout_peak_over = 1'b0;
  logic ext_latch_fault = 1'b0, ext_auto_fault = 1'b0;
  logic [11:0] vout_meas = 12'h000, vin_peak = 12'h000;
  int errors = 0;
  int compares = 0;

  always #5 aclk = ~aclk;

  // Short tick keeps restart and timeout waits to a few hundred cycles
  frc_top #(.TICK_CYCLES(20)) i_frc_top (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .supply_turn_on_level, .supply_turn_off_level, .supply_hold_low_level, .supply_hold_high_level,
    .supply_max_level, .cycle_current_limit, .hard_current_limit, .pwm_req, .vout_meas, .vin_peak,
    .iout_avg_over, .iout_peak_over, .ext_latch_fault, .ext_auto_fault, .switch_drive_out,
    .startup_cell_input, .current_limit_step, .drive_peak_source_current, .converter_running
  );

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bound(input int n);
    if (n >= 200)
    begin
      chk("wait bound", n, 199);
      tally_and_finish;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 200);
    bound(n);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 200);
    bound(n);
    d = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // Polls the status word; a state never reached counts as a mismatch
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      axi_rd(`FRC_OFF_STATUS, rd, 2'b00);
      n++;
    end
    while (rd[2:0] !== s && n < 200);
    chk("state", {29'h0, rd[2:0]}, {29'h0, s});
  endtask

  task automatic hold_check;
    supply_hold_low_level <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("cell on", startup_cell_input, 1'b1);
    supply_hold_low_level <= 1'b0;
    supply_hold_high_level <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("cell off", startup_cell_input, 1'b0);
    supply_hold_high_level <= 1'b0;
  endtask

  task automatic t_regs;
    chk("drive reset", drive_peak_source_current, 7'h1e);
    chk("cell reset", startup_cell_input, 1'b1);
    chk("gate reset", switch_drive_out, 1'b0);
    axi_rd(`FRC_OFF_DRIVE, rd, 2'b00);
    chk("drive reg", rd, `FRC_RST_DRIVE);
    axi_rd(8'h40, rd, 2'b10);
    chk("unmapped rdata", rd, 32'h0);
    axi_wr(8'h44, 32'h1, 2'b10);
    axi_wr(`FRC_OFF_DRIVE, 32'h7f, 2'b00);
    repeat (2) @(posedge aclk);
    chk("drive max", drive_peak_source_current, `FRC_DRV_MAX);
    axi_wr(`FRC_OFF_DRIVE, 32'h05, 2'b00);
    repeat (2) @(posedge aclk);
    chk("drive min", drive_peak_source_current, `FRC_DRV_MIN);
    $display("test regs done");
  endtask

  // Start-up that times out, waits, then restarts into regulation
  task automatic t_start;
    axi_wr(`FRC_OFF_SSTEP, 32'h0000_000a, 2'b00);
    axi_wr(`FRC_OFF_RESTART, 32'h0000_0208, 2'b00);
    axi_wr(`FRC_OFF_START, 32'h0005_0100, 2'b00);
    axi_wr(`FRC_OFF_OUTLVL, 32'h0000_0800, 2'b00);
    axi_wr(`FRC_OFF_CTRL, 32'h0000_0020, 2'b00);
    supply_turn_on_level <= 1'b1;
    wait_state(3'd2);
    chk("soft steps", current_limit_step, `FRC_SS_STEPS);
    wait_state(3'd4);
    axi_rd(`FRC_OFF_FAULT, rd, 2'b00);
    chk("startuv flag", rd[`FRC_F_STARTUV], 1'b1);
    chk("wait gate", switch_drive_out, 1'b0);
    hold_check;
    axi_wr(`FRC_OFF_FAULT, 32'h7ff, 2'b00);
    vout_meas <= 12'h300;
    wait_state(3'd3);
    chk("running", converter_running, 1'b1);
    $display("test start done");
  endtask

  task automatic t_gate;
    pwm_req <= 1'b1;
    cycle_current_limit <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("gate blanked", switch_drive_out, 1'b1);
    repeat (15) @(posedge aclk);
    chk("gate cut", switch_drive_out, 1'b0);
    cycle_current_limit <= 1'b0;
    hard_current_limit <= 1'b1;
    repeat (30) @(posedge aclk);
    hard_current_limit <= 1'b0;
    repeat (60) @(posedge aclk);
    axi_rd(`FRC_OFF_STATUS, rd, 2'b00);
    chk("short hard limit", rd[2:0], 3'd3);
    pwm_req <= 1'b0;
    @(posedge aclk);
    pwm_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("new pulse", switch_drive_out, 1'b1);
    iout_avg_over <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("auto gate off", switch_drive_out, 1'b0);
    iout_avg_over <= 1'b0;
    pwm_req <= 1'b0;
    wait_state(3'd4);
    wait_state(3'd3);
    $display("test gate done");
  endtask

  // One-cycle latch and auto faults together: the latch wins and ends in latch
  task automatic t_latch;
    pwm_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("run gate", switch_drive_out, 1'b1);
    ext_latch_fault <= 1'b1;
    ext_auto_fault <= 1'b1;
    @(posedge aclk);
    ext_latch_fault <= 1'b0;
    ext_auto_fault <= 1'b0;
    wait_state(3'd5);
    chk("latch gate", switch_drive_out, 1'b0);
    supply_max_level <= 1'b1;
    supply_turn_on_level <= 1'b0;
    supply_turn_off_level <= 1'b1;
    repeat (50) @(posedge aclk);
    axi_rd(`FRC_OFF_STATUS, rd, 2'b00);
    chk("latch holds", rd[2:0], 3'd5);
    axi_rd(`FRC_OFF_FAULT, rd, 2'b00);
    chk("vcc ov flag", rd[`FRC_F_VCCOV], 1'b1);
    supply_max_level <= 1'b0;
    pwm_req <= 1'b0;
    hold_check;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`FRC_OFF_STATUS, rd, 2'b00);
    chk("power-up off", rd[2:0], 3'd0);
    hard_current_limit <= 1'b1;
    repeat (70) @(posedge aclk);
    axi_rd(`FRC_OFF_STATUS, rd, 2'b00);
    chk("hard limit latch", rd[2:0], 3'd5);
    axi_rd(`FRC_OFF_FAULT, rd, 2'b00);
    chk("hard limit flag", rd[`FRC_F_HARDOC], 1'b1);
    hard_current_limit <= 1'b0;
    $display("test latch done");
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_start;
    t_gate;
    t_latch;
    tally_and_finish;
  end
endmodule
